/* File: logic/vocm_pkg.sv */
// Function
// - code 00: offsets 64, 512, 512, 64
// - code 01: offset 64 on all four
// - code 10: no offset on any channel
// - code 11: offsets 0, 512, 512, 0
// - clip mode from code and rounding width
// - 10-bit, code 00: colour 13-bit, or 12-bit with sync flags on pins one..four, key 11-bit
// - 10-bit, code 01: colour 12-bit, key 11-bit
// - 10-bit, code 11: all channels 4..1019
// - 8-bit, code 00: colour 11-bit, key 9-bit
// - 8-bit, code 01: colour 10-bit, key 9-bit
// - format from three output control bits
// - dual 4:2:2:4 muxed: 4:2:2 plus key with blanking in chroma slots
// - colour stream first port, key fourth port except in single link
// - dual 4:4:4:4 muxed: split into two streams
// - no timing reference words are inserted
// - port direction picks pins one/four or five/eight
// - single link: 4:4:4:4 on first port
// - non-multiplexed output ignores link count bit
`default_nettype none

package vocm_pkg;

	// register map of the plain register port
	localparam logic [7:0]  REG_CTRL_ADDR = 8'h00;
	localparam logic [7:0]  REG_STAT_ADDR = 8'h04;
	localparam logic [15:0] CTRL_RST      = 16'h0060;
	localparam logic [15:0] CTRL_WMASK    = 16'h07FF;
	localparam logic [15:0] ZERO_DATA     = 16'h0000;

	// offset set and clip codes
	localparam logic [1:0] OFS_SEL_STD   = 2'h0;
	localparam logic [1:0] OFS_SEL_ALL64 = 2'h1;
	localparam logic [1:0] OFS_SEL_NONE  = 2'h2;
	localparam logic [1:0] OFS_SEL_CHROM = 2'h3;
	localparam logic [1:0] CLIP_SGN_WIDE = 2'h0;
	localparam logic [1:0] CLIP_SGN_NARR = 2'h1;
	localparam logic [1:0] CLIP_UNS_FULL = 2'h2;
	localparam logic [1:0] CLIP_UNS_SAFE = 2'h3;

	typedef logic signed [13:0] vocm_wide_t;
	localparam vocm_wide_t OFS_0   = 14'sh0000;
	localparam vocm_wide_t OFS_64  = 14'sh0040;
	localparam vocm_wide_t OFS_512 = 14'sh0200;

	// clip limits, two's complement at 14 bits
	localparam vocm_wide_t S13_LO  = 14'sh3000;
	localparam vocm_wide_t S13_HI  = 14'sh0FFF;
	localparam vocm_wide_t S12_LO  = 14'sh3800;
	localparam vocm_wide_t S12_HI  = 14'sh07FF;
	localparam vocm_wide_t S11_LO  = 14'sh3C00;
	localparam vocm_wide_t S11_HI  = 14'sh03FF;
	localparam vocm_wide_t S10_LO  = 14'sh3E00;
	localparam vocm_wide_t S10_HI  = 14'sh01FF;
	localparam vocm_wide_t S9_LO   = 14'sh3F00;
	localparam vocm_wide_t S9_HI   = 14'sh00FF;
	localparam vocm_wide_t U10_HI  = 14'sh03FF;
	localparam vocm_wide_t U10S_LO = 14'sh0004;
	localparam vocm_wide_t U10S_HI = 14'sh03FB;
	localparam vocm_wide_t U8_HI   = 14'sh00FF;
	localparam vocm_wide_t U8S_LO  = 14'sh0001;
	localparam vocm_wide_t U8S_HI  = 14'sh00FE;

	// colour blanking levels and idle word
	localparam logic [12:0] BLANK_10  = 13'h0200;
	localparam logic [12:0] BLANK_8   = 13'h0080;
	localparam logic [12:0] ZERO_WORD = 13'h0000;

	// channel slots of a four-word group
	localparam int CH_Y   = 0;
	localparam int CH_CB  = 1;
	localparam int CH_CR  = 2;
	localparam int CH_KEY = 3;

	typedef struct packed {
		logic signed [12:0] y;
		logic signed [12:0] cb;
		logic signed [12:0] cr;
		logic signed [10:0] key;
	} vocm_smp_t;

	typedef struct packed {
		logic [4:0] rsvd;
		logic       filter_rounding_select;
		logic       port_dir;
		logic       sync_flag_output_enable;
		logic       link_count_select;
		logic       fmt_444_select;
		logic       output_interleave_n;
		logic       round_width_select;
		logic [1:0] clip_mode_select;
		logic [1:0] offset_set_select;
	} vocm_ctrl_t;

	typedef struct packed {
		logic [6:0] rsvd;
		logic [3:0] phase;
		logic       fmt_misuse;
		logic [3:0] clip_hit;
	} vocm_stat_t;

	typedef logic [3:0][12:0] vocm_word4_t;

	typedef enum logic [3:0] {
		PH_CB = 4'h1,
		PH_Y0 = 4'h2,
		PH_CR = 4'h4,
		PH_Y1 = 4'h8
	} vocm_phase_t;

	// offset of one channel for an offset set
	function automatic vocm_wide_t vocm_ofs(input logic [1:0] sel,
		input logic chroma);
		case (sel)
			OFS_SEL_STD:   return chroma ? OFS_512 : OFS_64;
			OFS_SEL_ALL64: return OFS_64;
			OFS_SEL_NONE:  return OFS_0;
			default:       return chroma ? OFS_512 : OFS_0;
		endcase
	endfunction

	// lower clip limit
	function automatic vocm_wide_t vocm_clip_lo(input logic round8,
		input logic [1:0] code, input logic is_key, input logic hvf);
		case ({round8, code})
			{1'b0, CLIP_SGN_WIDE}: return is_key ? S11_LO : (hvf ? S12_LO : S13_LO);
			{1'b0, CLIP_SGN_NARR}: return is_key ? S11_LO : S12_LO;
			{1'b0, CLIP_UNS_SAFE}: return U10S_LO;
			{1'b1, CLIP_SGN_WIDE}: return is_key ? S9_LO : S11_LO;
			{1'b1, CLIP_SGN_NARR}: return is_key ? S9_LO : S10_LO;
			{1'b1, CLIP_UNS_SAFE}: return U8S_LO;
			default:               return OFS_0;
		endcase
	endfunction

	// upper clip limit
	function automatic vocm_wide_t vocm_clip_hi(input logic round8,
		input logic [1:0] code, input logic is_key, input logic hvf);
		case ({round8, code})
			{1'b0, CLIP_SGN_WIDE}: return is_key ? S11_HI : (hvf ? S12_HI : S13_HI);
			{1'b0, CLIP_SGN_NARR}: return is_key ? S11_HI : S12_HI;
			{1'b0, CLIP_UNS_FULL}: return U10_HI;
			{1'b0, CLIP_UNS_SAFE}: return U10S_HI;
			{1'b1, CLIP_SGN_WIDE}: return is_key ? S9_HI : S11_HI;
			{1'b1, CLIP_SGN_NARR}: return is_key ? S9_HI : S10_HI;
			{1'b1, CLIP_UNS_FULL}: return U8_HI;
			default:               return U8S_HI;
		endcase
	endfunction

endpackage

`default_nettype wire

/* File: logic/vocm_clip.sv */
`default_nettype none

module vocm_clip #(
	parameter bit IS_KEY = 1'b0 // key channel limits
) (
	input  wire logic                 sys_clk,   // sample clock
	input  wire logic                 rst_n,     // async reset, low
	input  wire vocm_pkg::vocm_wide_t din,       // offset sample
	input  wire logic                 round8,    // 8-bit rounding
	input  wire logic [1:0]           code,      // clip mode code
	input  wire logic                 hvf_limit, // narrow 13-bit colour
	output logic [12:0]               dout_q,    // clipped word
	output logic                      hit_q      // limit exceeded
);
	import vocm_pkg::*;

	vocm_wide_t  lo_w;
	vocm_wide_t  hi_w;
	logic        over_w;
	logic        under_w;
	logic [12:0] dout_d;

	// limits from the clip mode and rounding width
	assign lo_w    = vocm_clip_lo(round8, code, IS_KEY, hvf_limit);
	assign hi_w    = vocm_clip_hi(round8, code, IS_KEY, hvf_limit);
	assign over_w  = din > hi_w;
	assign under_w = din < lo_w;
	// saturate, never wrap
	assign dout_d  = over_w ? hi_w[12:0] :
		(under_w ? lo_w[12:0] : din[12:0]);

	// registered result
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dout_q <= ZERO_WORD;
			hit_q  <= 1'b0;
		end else begin
			dout_q <= dout_d;
			hit_q  <= over_w | under_w;
		end
	end

endmodule

`default_nettype wire

/* File: logic/vocm_top.sv */
// Design decisions made here: the address map and the address-and-strobe port.
`default_nettype none

module vocm_top (
	input  wire logic                sys_clk,    // sample clock
	input  wire logic                rst_n,      // async reset, low
	input  wire logic [7:0]          reg_addr,   // register address
	input  wire logic [15:0]         reg_wdata,  // register write data
	input  wire logic                reg_wr,     // write strobe
	input  wire logic                reg_rd,     // read strobe
	output logic [15:0]              reg_rdata,  // read data, next cycle
	input  wire vocm_pkg::vocm_smp_t in_smp,     // sample from matrix
	input  wire logic                in_valid,   // sample present
	output vocm_pkg::vocm_word4_t    pin_lo_out, // pin ports one..four
	output logic                     pin_lo_oe,  // drive ports one..four
	output vocm_pkg::vocm_word4_t    pin_hi_out, // pin ports five..eight
	output logic                     pin_hi_oe,  // drive ports five..eight
	output logic                     out_valid   // pin words valid
);
	import vocm_pkg::*;

	vocm_ctrl_t  ctrl_q;
	vocm_ctrl_t  ctrl_d;
	logic [3:0]  hit_q;
	logic [3:0]  hit_w;
	logic        misuse_q;
	logic [15:0] rdata_d;
	vocm_wide_t  in_ext [4];
	vocm_wide_t  ofs_q  [4];
	logic        s1_valid_q;
	logic        s2_valid_q;
	logic [12:0] cv     [4];
	vocm_phase_t phase_q;
	vocm_phase_t phase_d;
	vocm_word4_t core_w;
	vocm_word4_t lo_d;
	vocm_word4_t hi_d;

	// register decode
	logic wr_ctrl;
	logic wr_stat;
	logic rd_ctrl;
	logic rd_stat;
	assign wr_ctrl = reg_wr && (reg_addr == REG_CTRL_ADDR);
	assign wr_stat = reg_wr && (reg_addr == REG_STAT_ADDR);
	assign rd_ctrl = reg_rd && (reg_addr == REG_CTRL_ADDR);
	assign rd_stat = reg_rd && (reg_addr == REG_STAT_ADDR);
	assign ctrl_d  = wr_ctrl ? vocm_ctrl_t'(reg_wdata & CTRL_WMASK) : ctrl_q;

	// mode decode from the output control bits
	logic muxed;
	logic single_link;
	logic dual_422;
	logic dual_444;
	logic hvf_limit;
	logic bad_fmt;
	assign muxed       = !ctrl_q.output_interleave_n;
	assign single_link = muxed && ctrl_q.link_count_select;
	assign dual_422    = muxed && !ctrl_q.link_count_select
		&& !ctrl_q.fmt_444_select;
	assign dual_444    = muxed && !ctrl_q.link_count_select
		&& ctrl_q.fmt_444_select;
	assign hvf_limit   = ctrl_q.sync_flag_output_enable && ctrl_q.port_dir;
	// multiplexed streams expect unsigned clipped data
	assign bad_fmt     = muxed && !ctrl_q.clip_mode_select[1];

	// status word
	vocm_stat_t stat_w;
	assign stat_w.rsvd       = '0;
	assign stat_w.phase      = phase_q;
	assign stat_w.fmt_misuse = misuse_q;
	assign stat_w.clip_hit   = hit_q;
	assign rdata_d = rd_ctrl ? ctrl_q :
		(rd_stat ? stat_w : ZERO_DATA);

	// control register and read data
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q    <= vocm_ctrl_t'(CTRL_RST);
			reg_rdata <= ZERO_DATA;
		end else begin
			ctrl_q    <= ctrl_d;
			reg_rdata <= rdata_d;
		end
	end

	// sticky status, write one to clear, a new event wins
	logic [3:0] hit_clr;
	logic       mis_clr;
	logic [3:0] hit_set;
	logic       mis_set;
	assign hit_clr = wr_stat ? reg_wdata[3:0] : 4'h0;
	assign mis_clr = wr_stat && reg_wdata[4];
	assign hit_set = s2_valid_q ? hit_w : 4'h0;
	assign mis_set = s2_valid_q && bad_fmt;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			hit_q    <= 4'h0;
			misuse_q <= 1'b0;
		end else begin
			hit_q    <= (hit_q & ~hit_clr) | hit_set;
			misuse_q <= (misuse_q && !mis_clr) || mis_set;
		end
	end

	// sign extension of the incoming channels
	assign in_ext[CH_Y]   = {in_smp.y[12], in_smp.y};
	assign in_ext[CH_CB]  = {in_smp.cb[12], in_smp.cb};
	assign in_ext[CH_CR]  = {in_smp.cr[12], in_smp.cr};
	assign in_ext[CH_KEY] = {{3{in_smp.key[10]}}, in_smp.key};

	// stage one: offset addition with the current offset set
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 4; i++) begin
				ofs_q[i] <= OFS_0;
			end
			s1_valid_q <= 1'b0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				ofs_q[i] <= in_ext[i] + vocm_ofs(ctrl_q.offset_set_select,
					(i == CH_CB) || (i == CH_CR));
			end
			s1_valid_q <= in_valid;
		end
	end

	// stage two: one clipper per channel
	for (genvar g = 0; g < 4; g++) begin : g_clip
		vocm_clip #(
			.IS_KEY (g == CH_KEY)
		) u_clip (
			.sys_clk   (sys_clk),
			.rst_n     (rst_n),
			.din       (ofs_q[g]),
			.round8    (ctrl_q.round_width_select),
			.code      (ctrl_q.clip_mode_select),
			.hvf_limit (hvf_limit),
			.dout_q    (cv[g]),
			.hit_q     (hit_w[g])
		);
	end

	// word phase of the multiplexed streams
	always_comb begin
		phase_d = phase_q;
		if (s2_valid_q) begin
			unique case (phase_q)
				PH_CB:   phase_d = PH_Y0;
				PH_Y0:   phase_d = PH_CR;
				PH_CR:   phase_d = PH_Y1;
				PH_Y1:   phase_d = PH_CB;
				default: phase_d = PH_CB;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_q    <= PH_CB;
			s2_valid_q <= 1'b0;
		end else begin
			phase_q    <= phase_d;
			s2_valid_q <= s1_valid_q;
		end
	end

	// stage three: stream formatting
	logic        ph_y;
	logic        ph_even;
	logic [12:0] blank_w;
	logic [12:0] chroma_w;
	logic [12:0] color_mux;
	logic [12:0] key_mux;
	assign ph_y     = (phase_q == PH_Y0) || (phase_q == PH_Y1);
	assign ph_even  = (phase_q == PH_CB) || (phase_q == PH_CR);
	assign blank_w  = ctrl_q.round_width_select ? BLANK_8 : BLANK_10;
	assign chroma_w = (phase_q == PH_CB) ? cv[CH_CB] : cv[CH_CR];
	// colour stream: Cb Y Cr Y, single link puts key in the last slot
	assign color_mux = !ph_y ? chroma_w :
		((phase_q == PH_Y1) && single_link ? cv[CH_KEY] : cv[CH_Y]);
	// key stream: zero in single link, else key on luma slots, blanking or chroma between
	assign key_mux = single_link ? ZERO_WORD :
		(ph_y ? cv[CH_KEY] : (dual_444 ? chroma_w : blank_w));

	// core ports: first carries colour, fourth carries key except in single link (zero there), no timing words
	assign core_w[0] = muxed ? color_mux : cv[CH_Y];
	assign core_w[1] = muxed ? ZERO_WORD :
		(ctrl_q.fmt_444_select ? cv[CH_CB] :
		(ph_even ? cv[CH_CB] : cv[CH_CR]));
	assign core_w[2] = (muxed || !ctrl_q.fmt_444_select) ? ZERO_WORD
		: cv[CH_CR];
	assign core_w[3] = muxed ? key_mux : cv[CH_KEY];

	// pin routing by port direction
	assign lo_d = ctrl_q.port_dir ? core_w : '0;
	assign hi_d = ctrl_q.port_dir ? '0 : core_w;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_lo_out <= '0;
			pin_hi_out <= '0;
			pin_lo_oe  <= 1'b0;
			pin_hi_oe  <= 1'b0;
			out_valid  <= 1'b0;
		end else begin
			pin_lo_out <= lo_d;
			pin_hi_out <= hi_d;
			pin_lo_oe  <= ctrl_q.port_dir;
			pin_hi_oe  <= !ctrl_q.port_dir;
			out_valid  <= s2_valid_q;
		end
	end

	// checks
	default clocking cb_chk @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	vocm_wide_t hi_y;
	assign hi_y = vocm_clip_hi(ctrl_q.round_width_select,
		ctrl_q.clip_mode_select, 1'b0, hvf_limit);

	a_ofs_std_set: assert property (
		in_valid && ctrl_q.offset_set_select == OFS_SEL_STD |=>
		ofs_q[CH_CB] == $past(in_ext[CH_CB]) + OFS_512 &&
		ofs_q[CH_KEY] == $past(in_ext[CH_KEY]) + OFS_64)
		else $error("offset set 00 wrong");

	a_ofs_all64_set: assert property (
		in_valid && ctrl_q.offset_set_select == OFS_SEL_ALL64 |=>
		ofs_q[CH_CR] == $past(in_ext[CH_CR]) + OFS_64 &&
		ofs_q[CH_Y] == $past(in_ext[CH_Y]) + OFS_64)
		else $error("offset set 01 wrong");

	a_ofs_none_set: assert property (
		in_valid && ctrl_q.offset_set_select == OFS_SEL_NONE |=>
		ofs_q[CH_Y] == $past(in_ext[CH_Y]) &&
		ofs_q[CH_KEY] == $past(in_ext[CH_KEY]))
		else $error("offset set 10 wrong");

	a_ofs_chroma_set: assert property (
		in_valid && ctrl_q.offset_set_select == OFS_SEL_CHROM |=>
		ofs_q[CH_CB] == $past(in_ext[CH_CB]) + OFS_512 &&
		ofs_q[CH_Y] == $past(in_ext[CH_Y]))
		else $error("offset set 11 wrong");

	a_clip_sat_high: assert property (
		ofs_q[CH_Y] > hi_y |=> cv[CH_Y] == $past(hi_y[12:0]))
		else $error("luma not saturated at maximum");

	a_clip_u10_safe: assert property (
		!ctrl_q.round_width_select &&
		ctrl_q.clip_mode_select == CLIP_UNS_SAFE [*2] |->
		cv[CH_KEY] >= U10S_LO[12:0] && cv[CH_KEY] <= U10S_HI[12:0])
		else $error("key outside 4..1019");

	a_clip_u8_safe: assert property (
		ctrl_q.round_width_select &&
		ctrl_q.clip_mode_select == CLIP_UNS_SAFE [*2] |->
		cv[CH_Y] >= U8S_LO[12:0] && cv[CH_Y] <= U8S_HI[12:0])
		else $error("luma outside 1..254");

	a_key_blank_slot: assert property (
		dual_422 && !ph_y && $stable(ctrl_q) |=>
		($past(ctrl_q.port_dir) ? pin_lo_out[3] : pin_hi_out[3])
		== $past(blank_w))
		else $error("key chroma slot not at blanking");

	a_port_route: assert property (
		ctrl_q.port_dir |=> pin_lo_oe && !pin_hi_oe &&
		pin_lo_out[0] == $past(core_w[0]) && pin_hi_out == '0)
		else $error("core ports not on pins one..four");

	a_nonmux_pass: assert property (
		!muxed && !ctrl_q.port_dir |=>
		pin_hi_out[3] == $past(cv[CH_KEY]) &&
		pin_hi_out[0] == $past(cv[CH_Y]))
		else $error("non-multiplexed words wrong");

	a_valid_latency: assert property (
		in_valid |-> ##3 out_valid)
		else $error("pipeline latency not three");

	c_dual_422: cover property (dual_422 && s2_valid_q && phase_q == PH_Y1);
	c_single: cover property (single_link && s2_valid_q && phase_q == PH_Y1);
	c_dual_444: cover property (dual_444 && s2_valid_q && ph_y);
	c_clip_hit: cover property (hit_q == 4'hF);

endmodule

`default_nettype wire

/* File: sim/vocm_sink.sv */
`default_nettype none

module vocm_sink (
	input  wire logic                  sys_clk,    // sample clock
	input  wire logic                  rst_n,      // async reset, low
	input  wire vocm_pkg::vocm_word4_t pin_lo_out, // ports one..four
	input  wire logic                  pin_lo_oe,  // ports one..four driven
	input  wire vocm_pkg::vocm_word4_t pin_hi_out, // ports five..eight
	input  wire logic                  pin_hi_oe,  // ports five..eight driven
	input  wire logic                  out_valid,  // words carry a sample
	output logic [15:0]                rx_count,   // samples taken in
	output logic                       rx_clash    // both groups driven
);
	import vocm_pkg::*;

	// receiver takes one word set per valid cycle; two drivers is a clash
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_count <= 16'h0000;
			rx_clash <= 1'b0;
		end else begin
			if (pin_lo_oe && pin_hi_oe)
				rx_clash <= 1'b1;
			if (out_valid && (pin_lo_oe || pin_hi_oe))
				rx_count <= rx_count + 16'h0001;
		end
	end
endmodule

`default_nettype wire

/* File: sim/vocm_tb_top.sv */
`default_nettype none

module vocm_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import vocm_pkg::*;

	typedef struct packed {
		logic [15:0] ctrl;
		logic [12:0] y, cb, cr;
		logic [10:0] key;
		logic [12:0] ey, ecb, ecr, ek;
	} vocm_row_t;

	logic        sys_clk;
	logic        rst_n;
	logic [7:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_rdata;
	vocm_smp_t   in_smp;
	logic        in_valid;
	vocm_word4_t pin_lo_out;
	logic        pin_lo_oe;
	vocm_word4_t pin_hi_out;
	logic        pin_hi_oe;
	logic        out_valid;
	logic [15:0] rx_count;
	logic        rx_clash;
	int          num_errors;
	int          num_checks;

	vocm_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .in_smp(in_smp), .in_valid(in_valid),
		.pin_lo_out(pin_lo_out), .pin_lo_oe(pin_lo_oe),
		.pin_hi_out(pin_hi_out), .pin_hi_oe(pin_hi_oe),
		.out_valid(out_valid));

	vocm_sink sink (.sys_clk(sys_clk), .rst_n(rst_n),
		.pin_lo_out(pin_lo_out), .pin_lo_oe(pin_lo_oe),
		.pin_hi_out(pin_hi_out), .pin_hi_oe(pin_hi_oe),
		.out_valid(out_valid), .rx_count(rx_count), .rx_clash(rx_clash));

	// 125 MHz sample clock
	always #4 sys_clk = ~sys_clk;

	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk16(input string nm, input logic [15:0] e, g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk13(input string nm, input logic [12:0] e, g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk1(input string nm, input logic e, g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %b seen %b", nm, e, g);
		end
	endtask

	// one-cycle register strobes, data in the following cycle
	task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	// one sample in, bounded wait for its words at the pins
	task automatic send(input logic [12:0] y, cb, cr, input logic [10:0] k);
		int n;
		@(posedge sys_clk);
		in_smp <= '{y, cb, cr, k};
		in_valid <= 1'b1;
		@(posedge sys_clk);
		in_valid <= 1'b0;
		// edges counted from the one that raised in_valid
		n = 1;
		#1;
		while (out_valid !== 1'b1 && n < 8) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		if (n == 8) begin
			chk1("out_valid", 1'b1, out_valid);
			complete_run();
		end else begin
			chk16("latency", 16'h0003, 16'(n));
		end
	endtask

	// reset held four cycles, outputs quiet meanwhile
	task automatic do_reset();
		logic [15:0] rd;
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
		chk1("pin_hi_oe", 1'b0, pin_hi_oe);
		chk13("pin_hi_word", 13'h0000, pin_hi_out[0]);
		@(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		#1;
		chk1("pin_hi_oe", 1'b1, pin_hi_oe);
		chk1("pin_lo_oe", 1'b0, pin_lo_oe);
		reg_read(REG_CTRL_ADDR, rd);
		chk16("ctrl_reset", 16'h0060, rd);
	endtask

	initial begin
		vocm_row_t   rows [12];
		vocm_word4_t w;
		logic [15:0] rd;
		logic [12:0] ec, ek;
		int          i, m, p;
		rows = '{
			'{16'h0060, 13'h0064, 13'h1DA8, 13'h0FA0, 11'h3E8,
				13'h00A4, 13'h1FA8, 13'h0FFF, 13'h03FF},
			'{16'h0061, 13'h1000, 13'h000A, 13'h1F9C, 11'h400,
				13'h1040, 13'h004A, 13'h1FDC, 13'h1C40},
			'{16'h0062, 13'h0FFF, 13'h1000, 13'h0000, 11'h7FF,
				13'h0FFF, 13'h1000, 13'h0000, 13'h1FFF},
			'{16'h0063, 13'h0FA0, 13'h0ED8, 13'h1000, 11'h1F4,
				13'h0FA0, 13'h0FFF, 13'h1200, 13'h01F4},
			'{16'h0066, 13'h0BB8, 13'h1448, 13'h0064, 11'h400,
				13'h07FF, 13'h1800, 13'h0064, 13'h1C00},
			'{16'h006A, 13'h1FFB, 13'h0400, 13'h01F4, 11'h7FF,
				13'h0000, 13'h03FF, 13'h01F4, 13'h0000},
			'{16'h006E, 13'h0003, 13'h03FC, 13'h0004, 11'h3FF,
				13'h0004, 13'h03FB, 13'h0004, 13'h03FB},
			'{16'h0072, 13'h0400, 13'h1BFF, 13'h1C00, 11'h100,
				13'h03FF, 13'h1C00, 13'h1C00, 13'h00FF},
			'{16'h0076, 13'h0200, 13'h1DFF, 13'h1E00, 11'h6FF,
				13'h01FF, 13'h1E00, 13'h1E00, 13'h1F00},
			'{16'h007A, 13'h0100, 13'h1FFF, 13'h00FF, 11'h12C,
				13'h00FF, 13'h0000, 13'h00FF, 13'h00FF},
			'{16'h007E, 13'h0000, 13'h00FF, 13'h00FE, 11'h001,
				13'h0001, 13'h00FE, 13'h00FE, 13'h0001},
			'{16'h00E2, 13'h0123, 13'h0456, 13'h0789, 11'h0AB,
				13'h0123, 13'h0456, 13'h0789, 13'h00AB}};
		sys_clk = 1'b0;
		rst_n = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		in_smp = '0;
		in_valid = 1'b0;
		num_errors = 0;
		num_checks = 0;
		do_reset();
		// offset sets, clip modes and non-multiplexed word order
		for (i = 0; i < 12; i++) begin
			reg_write(REG_CTRL_ADDR, rows[i].ctrl);
			send(rows[i].y, rows[i].cb, rows[i].cr, rows[i].key);
			chk13("y_word", rows[i].ey, pin_hi_out[CH_Y]);
			chk13("cb_word", rows[i].ecb, pin_hi_out[CH_CB]);
			chk13("cr_word", rows[i].ecr, pin_hi_out[CH_CR]);
			chk13("key_word", rows[i].ek, pin_hi_out[CH_KEY]);
		end
		// sticky clip hits, clear, masked control, unmapped place
		reg_read(REG_STAT_ADDR, rd);
		chk16("clip_hits", 16'h000F, rd & 16'h001F);
		reg_write(REG_STAT_ADDR, 16'h001F);
		reg_read(REG_STAT_ADDR, rd);
		chk16("clip_hits", 16'h0000, rd & 16'h001F);
		reg_write(REG_CTRL_ADDR, 16'hFFFF);
		reg_write(8'h08, 16'h0000);
		reg_read(REG_CTRL_ADDR, rd);
		chk16("ctrl_mask", 16'h07FF, rd);
		reg_read(8'h08, rd);
		chk16("unmapped", 16'h0000, rd);
		// mid-run reset, then dual 4:2:2:4, dual 4:4:4:4, single link
		do_reset();
		for (i = 0; i < 12; i++) begin
			m = i / 4;
			p = i % 4;
			if (p == 0) begin
				rd = m == 0 ? 16'h020A : (m == 1 ? 16'h004A : 16'h00CA);
				reg_write(REG_CTRL_ADDR, rd);
			end
			send(13'h0064 + 13'(i), 13'h00C8 + 13'(i), 13'h012C + 13'(i),
				11'h190 + 11'(i));
			ec = p == 0 ? 13'h00C8 + 13'(i) : (p == 2 ? 13'h012C + 13'(i) :
				(p == 3 && m == 2 ? 13'h0190 + 13'(i) : 13'h0064 + 13'(i)));
			ek = p[0] ? (m == 2 ? 13'h0000 : 13'h0190 + 13'(i)) :
				(m == 0 ? 13'h0200 : (m == 2 ? 13'h0000 :
				(p == 0 ? 13'h00C8 + 13'(i) : 13'h012C + 13'(i))));
			w = m == 0 ? pin_lo_out : pin_hi_out;
			chk13("color_word", ec, w[0]);
			chk13("key_word", ek, w[3]);
			chk1("other_oe", 1'b0, m == 0 ? pin_hi_oe : pin_lo_oe);
		end
		@(posedge sys_clk);
		#1;
		chk16("rx_count", 16'h000C, rx_count);
		chk1("rx_clash", 1'b0, rx_clash);
		// sync flags on ports one..four hold colour to 12 bits
		reg_write(REG_CTRL_ADDR, 16'h0362);
		send(13'h0FA0, 13'h1000, 13'h0000, 11'h3E8);
		chk13("y_word", 13'h07FF, pin_lo_out[CH_Y]);
		chk13("cb_word", 13'h1800, pin_lo_out[CH_CB]);
		chk13("key_word", 13'h03E8, pin_lo_out[CH_KEY]);
		// non-multiplexed 4:2:2:4, phase Y0 then Cr
		reg_write(REG_CTRL_ADDR, 16'h0022);
		for (i = 0; i < 2; i++) begin
			send(13'h0011, 13'h0022, 13'h0033, 11'h044);
			chk13("y_word", 13'h0011, pin_hi_out[CH_Y]);
			chk13("cb_cr_word", i ? 13'h0022 : 13'h0033, pin_hi_out[1]);
			chk13("empty_word", 13'h0000, pin_hi_out[CH_CR]);
			chk13("key_word", 13'h0044, pin_hi_out[CH_KEY]);
		end
		// dual 4:2:2:4 with 8-bit data, phase Y1 then Cb
		reg_write(REG_CTRL_ADDR, 16'h001A);
		for (i = 0; i < 2; i++) begin
			send(13'h0010, 13'h0020, 13'h0030, 11'h040);
			chk13("color_word", i ? 13'h0020 : 13'h0010, pin_hi_out[0]);
			chk13("key_word", i ? 13'h0080 : 13'h0040, pin_hi_out[3]);
		end
		// hits of Y and Cb, phase back at Y0
		reg_read(REG_STAT_ADDR, rd);
		chk16("status", 16'h0043, rd);
		complete_run();
	end
endmodule

`default_nettype wire
